//--- shtc_aux_model.sv
// Behavioural auxiliary bus engine with the target sensors behind it.
// Assumes one request at a time; gap sets the wait between bytes.
`timescale 1ns/1ps
module shtc_aux_model (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       xfer_req,
  input  wire       xfer_read,
  input  wire [2:0] xfer_read_count,
  input  wire [3:0] gap,
  output reg        rx_valid,
  output reg  [7:0] rx_data,
  output reg        xfer_done
);
  reg       busy;
  reg [2:0] left;
  reg [3:0] w;
  reg [7:0] seq;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {busy, left, w, rx_valid, xfer_done} <= 0;
      seq <= 8'h10;
      rx_data <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      xfer_done <= 1'b0;
      // Data line is inverted every cycle in which no byte is loaded
      rx_data <= ~rx_data;
      if (!busy) begin
        busy <= xfer_req && !xfer_done;
        left <= xfer_read ? xfer_read_count : 3'h0;
        w <= gap;
      end else if (w != 4'h0) w <= w - 4'h1;
      else if (left != 3'h0) begin
        rx_valid <= 1'b1;
        rx_data <= seq;
        seq <= seq + 8'h1;
        left <= left - 3'h1;
        w <= gap;
      end else begin
        xfer_done <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule // shtc_aux_model

//--- shtc_regs.vh
// Register map and field layout of the sensor hub target configuration bank.
// Assumes an APB bus with word addressing: byte address = index * 4.
`ifndef SHTC_REGS_VH
`define SHTC_REGS_VH

// Register indices
`define SHTC_IDX_HUB_OUT_FIRST   8'h02
`define SHTC_IDX_HUB_OUT_LAST    8'h13
`define SHTC_IDX_MASTER_CFG      8'h14
`define SHTC_IDX_T0_ADDR         8'h15
`define SHTC_IDX_T0_INDEX        8'h16
`define SHTC_IDX_T0_CFG          8'h17
`define SHTC_IDX_T1_ADDR         8'h18
`define SHTC_IDX_T1_INDEX        8'h19
`define SHTC_IDX_T1_CFG          8'h1a
`define SHTC_IDX_T2_ADDR         8'h1b
`define SHTC_IDX_T2_INDEX        8'h1c
`define SHTC_IDX_T2_CFG          8'h1d
`define SHTC_IDX_T3_ADDR         8'h1e
`define SHTC_IDX_T3_INDEX        8'h1f
`define SHTC_IDX_T3_CFG          8'h20
`define SHTC_IDX_STATUS          8'h22
`define SHTC_IDX_WIDTH           8
`define SHTC_CFG_COUNT           13
`define SHTC_HUB_OUT_COUNT       18
`define SHTC_SLOT_STRIDE         4'd3

// Address register fields
`define SHTC_ADDR_DIR_BIT        0
`define SHTC_ADDR_MSB            7
`define SHTC_ADDR_LSB            1

// Slot configuration fields
`define SHTC_CFG_RATE_MSB        7
`define SHTC_CFG_RATE_LSB        6
`define SHTC_CFG_BATCH_BIT       3
`define SHTC_CFG_COUNT_MSB       2
`define SHTC_CFG_COUNT_LSB       0

// Master configuration fields
`define SHTC_MC_SINGLE_WR_BIT    6
`define SHTC_MC_TRIG_SEL_BIT     5
`define SHTC_MC_SLOTS_MSB        1
`define SHTC_MC_SLOTS_LSB        0

// Status fields
`define SHTC_ST_WR_DONE_BIT      7
`define SHTC_ST_END_BIT          0

// Reset values
`define SHTC_RST_BYTE            8'h00
`define SHTC_RST_COUNT3          3'h0
`define SHTC_RST_SLOT            2'h0
`define SHTC_RST_PTR             5'h00

`endif

//--- shtc_target_config.v
// Sensor hub target configuration bank with its slot sequencer.
// Assumes an APB master on pclk and an external auxiliary bus engine that
// takes one transaction per request and reports bytes and completion.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "shtc_regs.vh"

// What this block does
// - Slot 0 seven-bit target address, reset zero
// - Slot 0 direction bit: 0 write, 1 read
// - Slot 0 eight-bit register index, reset zero
// - Hub rate field, slowed by sensor rate
// - Slot 0 FIFO batching enable bit 3
// - Slot 0 read count in bits 2:0
// - Slot 1 seven-bit address, read only target
// - Slot 1 read enable bit
// - Slot 1 register index, gated by enable
// - Slot 1 FIFO batching enable bit
// - Slot 1 read count field
// - Slot 2 seven-bit target address
// - Slot 2 read enable bit
// - Slot 2 register index, gated by enable
// - Slot 2 FIFO batching enable bit
// - Slot 2 read count field
// - Slot 3 seven-bit target address
// - Slot 3 read enable bit
// - Slot count selects one to four slots
// - Trigger select: data ready or external
// - Single write: slot 0 single_write_option
// - Read bytes fill hub output registers
module shtc_target_config #(
  parameter ADDR_W = 12
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              data_ready,
  input  wire [1:0]        sensor_rate_code,
  input  wire              ext_trigger,
  output reg               xfer_req,
  output reg  [6:0]        xfer_target_address,
  output reg               xfer_read,
  output reg  [7:0]        xfer_register_index,
  output reg  [2:0]        xfer_read_count,
  input  wire              rx_valid,
  input  wire [7:0]        rx_data,
  input  wire              xfer_done,
  output reg               batch_push,
  output reg  [1:0]        batch_slot,
  output reg               hub_cycle_end
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SCAN = 3'b010;
  localparam [2:0] ST_XFER = 3'b100;

  reg  [7:0] cfg_reg [0:`SHTC_CFG_COUNT-1];
  reg  [7:0] hub_out_reg [0:`SHTC_HUB_OUT_COUNT-1];
  reg  [2:0] state_reg;
  reg  [1:0] slot_reg;
  reg  [4:0] ptr_reg;
  reg  [2:0] decim_reg;
  reg        wr_done_reg;
  reg        end_reg;
  reg        first_cycle_reg;
  reg  [7:0] status_byte;
  reg  [7:0] rd_byte_next;
  integer    i;
  integer    j;

  // Index range test shared by the address decoders
  function idx_in_range;
    input [7:0] idx;
    input [7:0] lo;
    input [7:0] hi;
    begin
      idx_in_range = (idx >= lo) && (idx <= hi);
    end
  endfunction

  // Position of a register index inside the configuration array
  function [3:0] cfg_pos;
    input [7:0] idx;
    reg   [7:0] diff;
    begin
      diff = idx - `SHTC_IDX_MASTER_CFG;
      cfg_pos = diff[3:0];
    end
  endfunction

  wire [7:0] reg_idx = paddr[`SHTC_IDX_WIDTH+1:2];
  wire       aligned = (paddr[1:0] == 2'b00);
  wire       in_cfg = idx_in_range(reg_idx, `SHTC_IDX_MASTER_CFG, `SHTC_IDX_T3_CFG);
  wire       in_out = idx_in_range(reg_idx, `SHTC_IDX_HUB_OUT_FIRST, `SHTC_IDX_HUB_OUT_LAST);
  wire       in_st = (reg_idx == `SHTC_IDX_STATUS);
  wire       mapped = aligned && (in_cfg || (!pwrite && (in_out || in_st)));
  wire       wr_en = psel && penable && pwrite && mapped;
  wire [3:0] cfg_sel = cfg_pos(reg_idx);
  wire [7:0] out_off = reg_idx - `SHTC_IDX_HUB_OUT_FIRST;
  wire [4:0] out_sel = out_off[4:0];

  // Slot register bytes; slot 0 also carries the hub rate
  wire [7:0] master_cfg = cfg_reg[cfg_pos(`SHTC_IDX_MASTER_CFG)];
  wire [7:0] t0_addr_byte = cfg_reg[cfg_pos(`SHTC_IDX_T0_ADDR)];
  wire [7:0] t0_index_byte = cfg_reg[cfg_pos(`SHTC_IDX_T0_INDEX)];
  wire [7:0] t0_cfg_byte = cfg_reg[cfg_pos(`SHTC_IDX_T0_CFG)];
  wire [7:0] t1_addr_byte = cfg_reg[cfg_pos(`SHTC_IDX_T1_ADDR)];
  wire [7:0] t1_index_byte = cfg_reg[cfg_pos(`SHTC_IDX_T1_INDEX)];
  wire [7:0] t1_cfg_byte = cfg_reg[cfg_pos(`SHTC_IDX_T1_CFG)];
  wire [7:0] t2_addr_byte = cfg_reg[cfg_pos(`SHTC_IDX_T2_ADDR)];
  wire [7:0] t2_index_byte = cfg_reg[cfg_pos(`SHTC_IDX_T2_INDEX)];
  wire [7:0] t2_cfg_byte = cfg_reg[cfg_pos(`SHTC_IDX_T2_CFG)];
  wire [7:0] t3_addr_byte = cfg_reg[cfg_pos(`SHTC_IDX_T3_ADDR)];
  wire [7:0] t3_index_byte = cfg_reg[cfg_pos(`SHTC_IDX_T3_INDEX)];
  wire [7:0] t3_cfg_byte = cfg_reg[cfg_pos(`SHTC_IDX_T3_CFG)];
  wire       single_write_option = master_cfg[`SHTC_MC_SINGLE_WR_BIT];
  wire       trigger_select = master_cfg[`SHTC_MC_TRIG_SEL_BIT];
  wire [1:0] active_slot_count = master_cfg[`SHTC_MC_SLOTS_MSB:`SHTC_MC_SLOTS_LSB];
  wire [1:0] hub_poll_rate = t0_cfg_byte[`SHTC_CFG_RATE_MSB:`SHTC_CFG_RATE_LSB];

  // Zero wait states; errors on unmapped, misaligned or read-only writes
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Trigger decimation: hub rate relative to sensor rate
  function [2:0] decim_load;
    input [1:0] hub_code;
    input [1:0] sens_code;
    reg   [1:0] shift;
    begin
      shift = (hub_code > sens_code) ? (hub_code - sens_code) : 2'd0;
      decim_load = (3'd1 << shift) - 3'd1;
    end
  endfunction

  reg  [7:0] cur_addr;
  reg  [7:0] cur_index;
  reg  [7:0] cur_cfg;

  // register bytes of the slot under scan
  always @* begin
    cur_addr = t0_addr_byte;
    cur_index = t0_index_byte;
    cur_cfg = t0_cfg_byte;
    case (slot_reg)
      2'd0: begin
        cur_addr = t0_addr_byte;
        cur_index = t0_index_byte;
        cur_cfg = t0_cfg_byte;
      end
      2'd1: begin
        cur_addr = t1_addr_byte;
        cur_index = t1_index_byte;
        cur_cfg = t1_cfg_byte;
      end
      2'd2: begin
        cur_addr = t2_addr_byte;
        cur_index = t2_index_byte;
        cur_cfg = t2_cfg_byte;
      end
      2'd3: begin
        cur_addr = t3_addr_byte;
        cur_index = t3_index_byte;
        cur_cfg = t3_cfg_byte;
      end
      default: begin
        cur_addr = t0_addr_byte;
        cur_index = t0_index_byte;
        cur_cfg = t0_cfg_byte;
      end
    endcase
  end

  wire [2:0] cur_count = cur_cfg[`SHTC_CFG_COUNT_MSB:`SHTC_CFG_COUNT_LSB];
  wire       t0_write = (slot_reg == 2'd0) && !cur_addr[`SHTC_ADDR_DIR_BIT];
  wire       write_allowed = !single_write_option || first_cycle_reg;
  wire       read_allowed = cur_addr[`SHTC_ADDR_DIR_BIT] && (cur_count != `SHTC_RST_COUNT3);
  wire       slot_used = t0_write ? write_allowed : read_allowed;

  wire       drdy_fire = data_ready && (decim_reg == 3'd0);
  wire       trigger = trigger_select ? ext_trigger : drdy_fire;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decim_reg <= 3'd0;
    end else if (data_ready) begin
      if (decim_reg == 3'd0) begin
        decim_reg <= decim_load(hub_poll_rate, sensor_rate_code);
      end else begin
        decim_reg <= decim_reg - 3'd1;
      end
    end
  end

  // Configuration registers; all fields reset to zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `SHTC_CFG_COUNT; i = i + 1) begin
        cfg_reg[i] <= `SHTC_RST_BYTE;
      end
    end else if (wr_en) begin
      cfg_reg[cfg_sel] <= pwdata[7:0];
    end
  end

  // Hub cycle events shared by the sequencer and the flag logic
  wire       last_slot = (slot_reg == active_slot_count);
  wire       cycle_start = (state_reg == ST_IDLE) && trigger;
  wire       scan_close = (state_reg == ST_SCAN) && !slot_used && last_slot;
  wire       xfer_close = (state_reg == ST_XFER) && xfer_done && last_slot;
  wire       cycle_close = scan_close || xfer_close;
  wire       wr_finish = (state_reg == ST_XFER) && xfer_done && !xfer_read;
  wire       store_byte = (state_reg == ST_XFER) && rx_valid && xfer_read &&
                          (ptr_reg < `SHTC_HUB_OUT_COUNT);
  wire       batch_hit = xfer_read && cur_cfg[`SHTC_CFG_BATCH_BIT];

  // Request fields launched for the slot under scan
  wire [6:0] next_target_address = cur_addr[`SHTC_ADDR_MSB:`SHTC_ADDR_LSB];
  wire       next_read = !t0_write;
  // index used for the slot 0 write and for enabled reads
  wire [7:0] next_register_index = cur_index;
  // read count, none for the write
  wire [2:0] next_read_count = t0_write ? `SHTC_RST_COUNT3 : cur_count;

  // Status byte: single_write_option completion and end of hub cycle
  always @* begin
    status_byte = `SHTC_RST_BYTE;
    status_byte[`SHTC_ST_WR_DONE_BIT] = wr_done_reg;
    status_byte[`SHTC_ST_END_BIT] = end_reg;
  end

  // Read byte of the addressed register; zero when unmapped or misaligned
  always @* begin
    rd_byte_next = `SHTC_RST_BYTE;
    if (aligned && in_cfg) begin
      rd_byte_next = cfg_reg[cfg_sel];
    end else if (aligned && in_out) begin
      rd_byte_next = hub_out_reg[out_sel];
    end else if (aligned && in_st) begin
      rd_byte_next = status_byte;
    end
  end

  // Read data captured in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, rd_byte_next};
    end
  end

  // read bytes packed from the first output byte upward
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= `SHTC_RST_PTR;
      for (j = 0; j < `SHTC_HUB_OUT_COUNT; j = j + 1) begin
        hub_out_reg[j] <= `SHTC_RST_BYTE;
      end
    end else if (cycle_start) begin
      ptr_reg <= `SHTC_RST_PTR;
    end else if (store_byte) begin
      hub_out_reg[ptr_reg] <= rx_data;
      ptr_reg <= ptr_reg + 5'd1;
    end
  end

  // Status flags and single_write_option arming
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_done_reg <= 1'b0;
      end_reg <= 1'b0;
      first_cycle_reg <= 1'b1;
    end else begin
      if (wr_finish && single_write_option) begin
        wr_done_reg <= 1'b1;
      end
      if (cycle_close) begin
        end_reg <= 1'b1;
      end else if (cycle_start) begin
        end_reg <= 1'b0;
      end
      // rearmed while the option is off
      if (!single_write_option) begin
        first_cycle_reg <= 1'b1;
      end else if (cycle_close) begin
        first_cycle_reg <= 1'b0;
      end
    end
  end

  // Slot sequencer and transfer request outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      slot_reg <= `SHTC_RST_SLOT;
      xfer_req <= 1'b0;
      xfer_target_address <= 7'h00;
      xfer_read <= 1'b0;
      xfer_register_index <= `SHTC_RST_BYTE;
      xfer_read_count <= `SHTC_RST_COUNT3;
      batch_push <= 1'b0;
      batch_slot <= `SHTC_RST_SLOT;
      hub_cycle_end <= 1'b0;
    end else begin
      batch_push <= 1'b0;
      hub_cycle_end <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (cycle_start) begin
            slot_reg <= `SHTC_RST_SLOT;
            state_reg <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          if (slot_used) begin
            xfer_req <= 1'b1;
            xfer_target_address <= next_target_address;
            xfer_read <= next_read;
            xfer_register_index <= next_register_index;
            xfer_read_count <= next_read_count;
            state_reg <= ST_XFER;
          end else if (scan_close) begin
            hub_cycle_end <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            slot_reg <= slot_reg + 2'd1;
          end
        end
        ST_XFER: begin
          if (xfer_done) begin
            xfer_req <= 1'b0;
            if (batch_hit) begin
              batch_push <= 1'b1;
              batch_slot <= slot_reg;
            end
            if (xfer_close) begin
              hub_cycle_end <= 1'b1;
              state_reg <= ST_IDLE;
            end else begin
              slot_reg <= slot_reg + 2'd1;
              state_reg <= ST_SCAN;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          xfer_req <= 1'b0;
        end
      endcase
    end
  end

endmodule // shtc_target_config

//--- shtc_target_config_bench.sv
// Self-checking bench for the target configuration bank.
// Assumes the aux model answers transfers; byte address is index times four.
`timescale 1ns/1ps
module shtc_target_config_bench;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0, lfsr = 32'h604e373c;
  reg         data_ready = 0, ext_trigger = 0, req_q = 0;
  reg  [1:0]  sensor_rate_code = 0;
  reg  [3:0]  gap = 0;
  reg  [7:0]  q, d, x;
  reg  [18:0] logv [0:31];
  wire [31:0] prdata;
  wire        pready, pslverr, xfer_req, xfer_read, rx_valid, xfer_done, batch_push;
  wire        hub_cycle_end;
  wire [6:0]  xfer_target_address;
  wire [7:0]  xfer_register_index, rx_data;
  wire [2:0]  xfer_read_count;
  wire [1:0]  batch_slot;
  integer     n_errors = 0, cmp_count = 0, n_end = 0, n_push = 0, n_log = 0, i, k, b;
  localparam [95:0] HUBCFG = 96'h55_0b_0a_63_20_01_80_00_03_1b_44_0b;
  always #2.5 pclk = ~pclk;
  shtc_target_config u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_ready(data_ready), .sensor_rate_code(sensor_rate_code), .ext_trigger(ext_trigger),
    .xfer_req(xfer_req), .xfer_target_address(xfer_target_address), .xfer_read(xfer_read),
    .xfer_register_index(xfer_register_index), .xfer_read_count(xfer_read_count),
    .rx_valid(rx_valid), .rx_data(rx_data), .xfer_done(xfer_done), .batch_push(batch_push),
    .batch_slot(batch_slot), .hub_cycle_end(hub_cycle_end)
  );
  shtc_aux_model u_aux (
    .pclk(pclk), .presetn(presetn), .xfer_req(xfer_req), .xfer_read(xfer_read),
    .xfer_read_count(xfer_read_count), .gap(gap), .rx_valid(rx_valid), .rx_data(rx_data),
    .xfer_done(xfer_done)
  );
  always @(posedge pclk) begin
    req_q <= xfer_req;
    if (xfer_req === 1'b1 && req_q !== 1'b1 && n_log < 32) begin
      logv[n_log] = {xfer_target_address, xfer_read, xfer_register_index, xfer_read_count};
      n_log = n_log + 1;
    end
    if (hub_cycle_end === 1'b1) n_end = n_end + 1;
    if (batch_push === 1'b1) n_push = n_push + 1;
  end
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] msk(input [7:0] idx);
    msk = (idx == 8'h17) ? 8'hcf : (idx == 8'h1a || idx == 8'h1d || idx == 8'h20) ? 8'h0f : 8'hff;
  endfunction
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [8*8:1] n, input [31:0] ex, input [31:0] s);
    begin
      cmp_count = cmp_count + 1;
      if (s !== ex) begin
        n_errors = n_errors + 1;
        $display("wrong value %0s expected %h seen %h", n, ex, s);
      end
    end
  endtask
  task apb(input w, input [7:0] idx, input [1:0] lo, input [7:0] wd);
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= {2'h0, idx, lo};
      pwdata <= {24'h0, wd};
      @(posedge pclk) penable <= 1;
      @(posedge pclk);
      for (k = 0; pready !== 1'b1; k = k + 1) begin
        if (k == 16) begin n_errors = n_errors + 1; conclude; end
        @(posedge pclk);
      end
      q = prdata[7:0];
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  task trig(input ext);
    begin
      if (ext) ext_trigger <= 1; else data_ready <= 1;
      @(posedge pclk) {ext_trigger, data_ready} <= 2'b00;
      for (k = 0; k < 120 && hub_cycle_end !== 1'b1; k = k + 1) @(posedge pclk);
      repeat (3) @(posedge pclk);
    end
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 8'h14; i <= 8'h20; i = i + 1) begin apb(0, i[7:0], 0, 0); chk("reset", 0, q); end
    $display("test reset done");
    for (i = 0; i < 24; i = i + 1) begin
      lfsr = nx(lfsr);
      x = 8'h15 + lfsr[11:8] % 4'd12;
      d = lfsr[7:0] & msk(x);
      apb(1, x, 0, d);
      chk("wr err", 0, e);
      apb(0, x, 0, 0);
      chk("readback", d, q);
    end
    apb(1, 8'h02, 0, 8'h5a); chk("ro err", 1, e);
    apb(0, 8'h02, 0, 0); chk("ro byte", 0, q);
    apb(0, 8'h30, 0, 0); chk("unmapped", 1, {q, e});
    apb(0, 8'h15, 2'h2, 0); chk("misalign", 1, e);
    $display("test access done");
    gap <= 4'h2;
    for (i = 0; i < 12; i = i + 1) apb(1, 8'h15 + i[7:0], 0, HUBCFG[95 - 8 * i -: 8]);
    apb(1, 8'h14, 0, 8'h23);
    n_log = 0;
    trig(1);
    chk("slots", 3, n_log);
    chk("slot0", {7'h2a, 1'b1, 8'h0b, 3'h2}, logv[0]);
    chk("slot1", {7'h31, 1'b1, 8'h20, 3'h1}, logv[1]);
    chk("slot3", {7'h0d, 1'b1, 8'h44, 3'h3}, logv[2]);
    for (i = 0; i < 6; i = i + 1) begin apb(0, 8'h02 + i[7:0], 0, 0); chk("hub", 8'h10 + i, q); end
    chk("push", 2, n_push);
    chk("bslot", 3, batch_slot);
    chk("end", 1, n_end);
    $display("test hub done");
    gap <= 4'h0;
    apb(1, 8'h15, 0, 8'h54);
    apb(1, 8'h14, 0, 8'h60);
    n_log = 0;
    trig(1);
    trig(1);
    chk("once", 1, n_log);
    chk("write", {7'h2a, 1'b0, 8'h0b}, logv[0][18:3]);
    apb(0, 8'h22, 0, 0); chk("status", 8'h81, q);
    apb(1, 8'h14, 0, 8'h20);
    n_log = 0;
    trig(1);
    trig(1);
    chk("repeat", 2, n_log);
    $display("test write done");
    apb(1, 8'h14, 0, 8'h00);
    for (i = 0; i < 5; i = i + 1) begin
      sensor_rate_code <= (i == 4) ? 2'h3 : 2'h0;
      apb(1, 8'h17, 0, {(i == 4) ? 2'h3 : i[1:0], 6'h02});
      b = n_end;
      repeat (8) trig(0);
      trig(1);
      chk("rate", (i == 4) ? 8 : 8 >> i, n_end - b);
    end
    $display("test rate done");
    conclude;
  end
endmodule // shtc_target_config_bench

//--- shtc_target_config_monitor.sv
// Checker on the ports of the target configuration bank.
// Assumes it is bound to every instance of the bank.
`timescale 1ns/1ps
module shtc_monitor (
  input wire       pclk,
  input wire       presetn,
  input wire       xfer_req,
  input wire [6:0] xfer_target_address,
  input wire       xfer_read,
  input wire [7:0] xfer_register_index,
  input wire [2:0] xfer_read_count,
  input wire       xfer_done,
  input wire       batch_push,
  input wire       hub_cycle_end
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_open; xfer_req && !xfer_done; endsequence
  sequence s_close; xfer_req && xfer_done; endsequence
  property p_hold; s_open |=> xfer_req; endproperty
  property p_stable; s_open |=> $stable({xfer_target_address, xfer_read,
    xfer_register_index, xfer_read_count}); endproperty
  property p_drop; s_close |=> !xfer_req; endproperty
  property p_rdcnt; $rose(xfer_req) && xfer_read |-> xfer_read_count != 3'h0; endproperty
  property p_push; batch_push |-> $past(xfer_done && xfer_read); endproperty
  property p_pulse; batch_push |=> !batch_push; endproperty
  property p_idle; hub_cycle_end |-> !xfer_req; endproperty
  property p_endp; hub_cycle_end |=> !hub_cycle_end; endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  a_stable: assert property (p_stable) else $error("request fields moved");
  a_drop: assert property (p_drop) else $error("request kept after done");
  a_rdcnt: assert property (p_rdcnt) else $error("read with zero count");
  a_push: assert property (p_push) else $error("push without read end");
  a_pulse: assert property (p_pulse) else $error("push too long");
  a_idle: assert property (p_idle) else $error("cycle end while busy");
  a_endp: assert property (p_endp) else $error("cycle end too long");
endmodule // shtc_monitor
bind shtc_target_config shtc_monitor u_mon (
  .pclk(pclk),
  .presetn(presetn),
  .xfer_req(xfer_req),
  .xfer_target_address(xfer_target_address),
  .xfer_read(xfer_read),
  .xfer_register_index(xfer_register_index),
  .xfer_read_count(xfer_read_count),
  .xfer_done(xfer_done),
  .batch_push(batch_push),
  .hub_cycle_end(hub_cycle_end)
);
